// ==== hw/pbad_pkg.sv ====
package pbad_pkg;

  // ----------------------------------------------------------------
  // Configuration offsets
  // ----------------------------------------------------------------
  localparam logic [7:0]  OFF_FIRST_BAR = 8'h10;
  localparam logic [7:0]  OFF_IMG0      = 8'h18;
  localparam logic [7:0]  OFF_IMG1      = 8'h1C;

  // ----------------------------------------------------------------
  // Field layout and reset values
  // ----------------------------------------------------------------
  localparam int          REG_LSB       = 12;
  localparam int          IMG_LSB       = 16;
  localparam int          READS_SIDE_EFFECT_FREE_FLAG_BIT      = 3;
  localparam int          KIND_BIT      = 0;
  localparam int          BS_W          = 4;
  localparam int          IMGS          = 2;
  localparam logic [15:0] FULL_MASK     = 16'hFFFF;
  localparam logic [19:0] RST_REG_BASE  = 20'h00000;
  localparam logic [15:0] RST_IMG_BASE  = 16'h0000;
  localparam logic [31:0] ZERO_WORD     = 32'h00000000;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  // One register access, used for PCI configuration and local bus
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  off;
    logic [31:0] wdata;
  } pbad_acc_s;

  // Values handed over by the EEPROM loader
  typedef struct packed {
    logic            done;
    logic [IMGS-1:0] en;
    logic [IMGS-1:0] reads_side_effect_free_flag;
    logic [IMGS-1:0] kind;
  } pbad_eep_s;

  // Result of one address phase
  typedef struct packed {
    logic            hit_regs;
    logic [11:0]     reg_sel;
    logic [IMGS-1:0] hit_img;
    logic            msg_fwd;
    logic            msg_rsvd;
  } pbad_dec_s;

endpackage : pbad_pkg

// ==== hw/pbad_sync3.sv ====
`timescale 1ns/1ps

// Three-stage pin synchroniser; output moves once stages two and three agree
module pbad_sync3 #(
  parameter int W = 1
) (
  // Clock
  input  wire logic         clock,
  input  wire logic         ce,
  // Data
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);

  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;

  // A synchroniser with no bits has nothing to carry
  if (W < 1)
  begin : g_bad_width
    $error("pbad_sync3 needs W of at least 1");
  end

  // No reset here so that straps can be sampled while reset is held
  always_ff @(posedge clock)
  begin
    if (ce)
    begin
      s1_q <= din;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q)
        dout <= s3_q;
    end
  end

endmodule : pbad_sync3

// ==== hw/pbad_bars.sv ====
`timescale 1ns/1ps

module pbad_bars
  import pbad_pkg::*;
(
  // Clock and reset
  input  wire logic                   clock,
  input  wire logic                   rst,
  input  wire logic                   ce,
  // Reset straps from pins
  input  wire logic                   eeprom_data_strap,
  input  wire logic                   id_load_strap_pin,
  input  wire logic                   pci_disable_strap,
  // EEPROM loader
  input  wire pbad_eep_s              eep,
  // Settings from the control registers
  input  wire logic                   messaging_unit_enable,
  input  wire logic [IMGS-1:0][BS_W-1:0] block_size_code,
  input  wire logic [IMGS-1:0]        local_prefetch_enable,
  // PCI configuration access
  input  wire pbad_acc_s              cfg,
  output logic      [31:0]            cfg_rdata,
  // Local processor bus register write
  input  wire pbad_acc_s              lpb,
  // PCI address phase
  input  wire logic                   addr_phase,
  input  wire logic [31:0]            pci_ad,
  // Decode results and image status
  output pbad_dec_s                   dec,
  output logic      [IMGS-1:0]        img_enabled,
  output logic      [IMGS-1:0]        img_prefetch
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [19:0]                reg_base;
    logic                       reg_written;
    logic [IMGS-1:0][15:0]      img_base;
    logic [IMGS-1:0]            reads_side_effect_free_flag;
    logic [IMGS-1:0]            kind;
    logic [IMGS-1:0]            eep_en;
    logic                       loaded;
    logic                       strap_id;
    logic                       strap_dis;
    logic [IMGS-1:0]            en;
    logic [31:0]                rdata;
    pbad_dec_s                  dec;
    logic [IMGS-1:0]            pf;
  } pbad_state_s;

  pbad_state_s q;
  pbad_state_s n;
  logic [2:0]  pins_sync;
  pbad_acc_s   src [2];
  logic [IMGS-1:0][15:0] mask;

  // ----------------------------------------------------------------
  // Strap synchronisers
  // ----------------------------------------------------------------
  pbad_sync3 #(
    .W (3)
  ) u_strap_sync (
    .clock (clock),
    .ce    (ce),
    .din   ({pci_disable_strap, id_load_strap_pin, eeprom_data_strap}),
    .dout  (pins_sync)
  );

  // Writable part of an image base for a block size code
  function automatic logic [15:0] img_mask(input logic [BS_W-1:0] bs);
    return FULL_MASK << bs;
  endfunction : img_mask

  // Word seen on a read of an image base
  // A disabled image shows all zeros whatever its flops hold
  function automatic logic [31:0] img_word(input pbad_state_s s, input int i,
                                           input logic [15:0] m);
    logic [31:0] w;
    w = ZERO_WORD;
    if (s.en[i])
    begin
      w[31:IMG_LSB] = s.img_base[i] & m;
      w[READS_SIDE_EFFECT_FREE_FLAG_BIT]   = s.reads_side_effect_free_flag[i];
      w[KIND_BIT]   = s.kind[i];
    end
    return w;
  endfunction : img_word

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb
  begin
    logic [31:0] reg_word;
    logic        sel_reg;
    logic [IMGS-1:0] sel_img;
    logic [31:0] off_in;
    logic        in_img;
    reg_word = ZERO_WORD;
    sel_reg  = 1'b0;
    sel_img  = '0;
    off_in   = ZERO_WORD;
    in_img   = 1'b0;
    n        = q;
    src[0]   = cfg;
    src[1]   = lpb;
    // Writable masks follow the live block size codes, so a new code acts at once
    for (int i = 0; i < IMGS; i++)
      mask[i] = img_mask(block_size_code[i]);

    // Straps are caught while reset is held; synchronous reset allows it
    if (rst)
    begin
      n             = '0;
      n.reg_base    = RST_REG_BASE;
      n.img_base    = {IMGS{RST_IMG_BASE}};
      n.strap_id    = pins_sync[0] | pins_sync[1];
      n.strap_dis   = pins_sync[2];
    end
    else
    begin
      // EEPROM results arrive once, at the end of loading
      if (eep.done)
      begin
        n.loaded = 1'b1;
        n.eep_en = eep.en;
        n.reads_side_effect_free_flag   = eep.reads_side_effect_free_flag;
        n.kind   = eep.kind;
      end
      // Image enables
      for (int i = 0; i < IMGS; i++)
        n.en[i] = q.strap_dis | (q.strap_id & q.loaded & q.eep_en[i]);

      // Writes from PCI then local bus, so the local bus wins a tie
      // Image writes see the flopped enable: a write in its first cycle is lost
      for (int s = 0; s < 2; s++)
      begin
        sel_reg = (src[s].off == OFF_FIRST_BAR && !messaging_unit_enable)
                | (src[s].off == OFF_IMG0 && messaging_unit_enable);
        sel_img[0] = (src[s].off == OFF_FIRST_BAR && messaging_unit_enable)
                   | (src[s].off == OFF_IMG0 && !messaging_unit_enable);
        sel_img[1] = (src[s].off == OFF_IMG1);
        if (src[s].wr)
        begin
          if (sel_reg)
          begin
            n.reg_base    = src[s].wdata[31:REG_LSB];
            n.reg_written = 1'b1;
          end
          for (int i = 0; i < IMGS; i++)
          begin
            // Bits under the block size keep their old value
            if (sel_img[i] && q.en[i])
            begin
              n.img_base[i] = (src[s].wdata[31:IMG_LSB] & mask[i])
                            | (q.img_base[i] & ~mask[i]);
              if (s == 1)
                n.reads_side_effect_free_flag[i] = src[s].wdata[READS_SIDE_EFFECT_FREE_FLAG_BIT];
            end
          end
        end
      end

      // Configuration read, answered one cycle later
      reg_word[31:REG_LSB] = q.reg_base;
      n.rdata = ZERO_WORD;
      if (cfg.rd)
      begin
        case (cfg.off)
          OFF_FIRST_BAR:
            n.rdata = messaging_unit_enable ? img_word(q, 0, mask[0]) : reg_word;
          OFF_IMG0:
            n.rdata = messaging_unit_enable ? reg_word : img_word(q, 0, mask[0]);
          OFF_IMG1:
            n.rdata = img_word(q, 1, mask[1]);
          default:
            n.rdata = ZERO_WORD;
        endcase
      end

      // Address phase decode, a one-cycle pulse
      n.dec = '0;
      if (addr_phase)
      begin
        if (q.reg_written && pci_ad[31:REG_LSB] == q.reg_base)
        begin
          n.dec.hit_regs = 1'b1;
          n.dec.reg_sel  = pci_ad[REG_LSB-1:0];
        end
        for (int i = 0; i < IMGS; i++)
          n.dec.hit_img[i] = q.en[i]
            && ((pci_ad[31:IMG_LSB] ^ q.img_base[i]) & mask[i]) == '0;
        // With messaging_unit_enable set, the first base maps local bus memory; its lowest 4K is reserved
        off_in = pci_ad & ~{mask[0], 16'h0000};
        in_img = n.dec.hit_img[0] && messaging_unit_enable;
        n.dec.msg_rsvd = in_img && off_in[31:REG_LSB] == '0;
        n.dec.msg_fwd  = in_img && off_in[31:REG_LSB] != '0;
      end

      // The flag only advertises; the control enable drives prefetching
      n.pf = local_prefetch_enable & q.en;
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  // Reset overrides the enable, but the strap synchroniser only moves with ce, so with the clock held the straps caught are its last values
  always_ff @(posedge clock)
  begin
    if (ce || rst)
      q <= n;
  end

  // Every output is a field of the state register
  assign cfg_rdata    = q.rdata;
  assign dec          = q.dec;
  assign img_enabled  = q.en;
  assign img_prefetch = q.pf;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  sequence s_reg_read;
    ce && cfg.rd && ((cfg.off == OFF_FIRST_BAR && !messaging_unit_enable)
                  || (cfg.off == OFF_IMG0 && messaging_unit_enable));
  endsequence

  sequence s_reg_hit;
    ce && addr_phase && q.reg_written && pci_ad[31:REG_LSB] == q.reg_base;
  endsequence

  a_space_zero: assert property (s_reg_read |=> cfg_rdata[REG_LSB-1:0] == '0
    && cfg_rdata[31:REG_LSB] == $past(q.reg_base))
    else $error("register base read wrong");

  a_reg_hit: assert property (s_reg_hit |=> dec.hit_regs
    && dec.reg_sel == $past(pci_ad[REG_LSB-1:0]))
    else $error("register space hit missed");

  a_no_early_hit: assert property (!q.reg_written |-> !dec.hit_regs)
    else $error("register hit before base write");

  a_dis_zero: assert property (ce && cfg.rd && cfg.off == OFF_IMG1 && !q.en[1]
    |=> cfg_rdata == ZERO_WORD)
    else $error("disabled image read not zero");

  a_img0_off: assert property (ce && cfg.rd && cfg.off == OFF_IMG0
    && !messaging_unit_enable && !q.en[0] |=> cfg_rdata == ZERO_WORD)
    else $error("disabled image0 read not zero");

  a_low_bits: assert property (ce && cfg.rd && cfg.off == OFF_IMG1
    |=> (cfg_rdata[31:IMG_LSB] & ~$past(mask[1])) == '0
      && cfg_rdata[15:4] == '0 && cfg_rdata[2:1] == '0)
    else $error("image read shows bits below block size");

  a_pci_reads_side_effect_free_flag: assert property (ce && cfg.wr && !lpb.wr && !eep.done
    |=> q.reads_side_effect_free_flag == $past(q.reads_side_effect_free_flag))
    else $error("PCI write changed prefetchable flag");

  a_dis_write: assert property (ce && !q.en[1] && !eep.done
    |=> q.img_base[1] == $past(q.img_base[1]))
    else $error("disabled image base changed");

  a_strap_en: assert property (ce && q.strap_dis |=> img_enabled[0])
    else $error("pci disable strap did not enable image0");

  a_msg_split: assert property (!(dec.msg_fwd && dec.msg_rsvd)
    && (!dec.msg_fwd || dec.hit_img[0])
    && (!dec.msg_rsvd || dec.hit_img[0]))
    else $error("messaging window split wrong");

  a_prefetch: assert property (ce |=> img_prefetch
    == ($past(local_prefetch_enable) & $past(q.en)))
    else $error("prefetch enable not followed");

endmodule : pbad_bars

// ==== verif/pbad_host.sv ====
`timescale 1ns/1ps

// PCI host; lines it lets go are scrambled, never left holding old values
module pbad_host
  import pbad_pkg::*;
(
  // Clock
  input  wire logic        clock,
  // Requests
  output pbad_acc_s        cfg,
  output logic             addr_phase,
  output logic [31:0]      pci_ad,
  // Answers
  input  wire logic [31:0] cfg_rdata,
  input  wire pbad_dec_s   dec
);
  // Config cycle; read data is taken one edge after the request
  task automatic acc(input logic w, input logic [7:0] o,
                     input logic [31:0] v, output logic [31:0] q);
    @(posedge clock);
    #1;
    cfg = '{w, ~w, o, v};
    @(posedge clock);
    #1;
    cfg = '{1'b0, 1'b0, ~o, ~v};
    q = cfg_rdata;
  endtask : acc

  // Address phase; decode pulses stand only the cycle after
  task automatic phase(input logic [31:0] a, output pbad_dec_s q);
    @(posedge clock);
    #1;
    addr_phase = 1'b1;
    pci_ad = a;
    @(posedge clock);
    #1;
    addr_phase = 1'b0;
    pci_ad = ~a;
    q = dec;
  endtask : phase

  // Idle host from time zero
  initial
  begin
    cfg = '0;
    addr_phase = 1'b0;
    pci_ad = 32'h00000000;
  end
endmodule : pbad_host

// ==== verif/pbad_bars_tb.sv ====
`timescale 1ns/1ps

// Bench for the base registers and address decode
module pbad_bars_tb
  import pbad_pkg::*;
;
  // ----------
  // Signals
  // ----------
  logic            clock = 1'b0, rst = 1'b1, ce = 1'b1, mue = 1'b0, aph;
  logic [2:0]      strap = 3'b000; // Data, id load, pci disable
  logic [1:0]      lpe = 2'b00, ien, ipf;
  logic [1:0][3:0] bsc = '0;
  logic [31:0]     rdata, ad, q;
  pbad_eep_s       eep = '0;
  pbad_acc_s       cfg, lpb = '0;
  pbad_dec_s       dec, d;
  int              err_total = 0, samples_checked = 0, cycles = 0;

  always #2.5 clock = ~clock;

  pbad_bars dut (
    .clock(clock), .rst(rst), .ce(ce),
    .eeprom_data_strap(strap[2]), .id_load_strap_pin(strap[1]),
    .pci_disable_strap(strap[0]), .eep(eep),
    .messaging_unit_enable(mue), .block_size_code(bsc),
    .local_prefetch_enable(lpe), .cfg(cfg), .cfg_rdata(rdata), .lpb(lpb),
    .addr_phase(aph), .pci_ad(ad), .dec(dec), .img_enabled(ien),
    .img_prefetch(ipf)
  );

  pbad_host host (
    .clock(clock), .cfg(cfg), .addr_phase(aph), .pci_ad(ad),
    .cfg_rdata(rdata), .dec(dec)
  );

  // Hang guard; the full run needs well under a thousand cycles
  always @(posedge clock)
  begin
    cycles <= cycles + 1;
    if (cycles == 5000)
    begin
      err_total++;
      tally_and_finish();
    end
  end

  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e)
    begin
      err_total++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : tally_and_finish

  // Straps only count while reset is held, so set them first
  task automatic do_reset(input logic [2:0] s);
    @(posedge clock);
    #1;
    rst = 1'b1;
    strap = s;
    repeat (10) @(posedge clock);
    #1;
    rst = 1'b0;
  endtask : do_reset

  // Loader hand-over pulse; enables settle two edges later
  task automatic load(input logic [1:0] e, input logic [1:0] k);
    @(posedge clock);
    #1;
    eep = '{1'b1, e, 2'b00, k};
    @(posedge clock);
    #1;
    eep.done = 1'b0;
    repeat (2) @(posedge clock);
    #1;
  endtask : load

  task automatic lwr(input logic [7:0] o, input logic [31:0] v);
    @(posedge clock);
    #1;
    lpb = '{1'b1, 1'b0, o, v};
    @(posedge clock);
    #1;
    lpb = '0;
  endtask : lwr

  // ----------
  // Scenarios
  // ----------
  task automatic t_refused();
    host.acc(1'b0, OFF_FIRST_BAR, 32'h0, q);
    chk("base rst", q, 32'h00000000);
    host.acc(1'b1, OFF_IMG0, 32'hFFFFFFFF, q);
    host.acc(1'b0, OFF_IMG0, 32'h0, q);
    chk("img0 off", q, 32'h00000000);
    host.acc(1'b1, OFF_IMG1, 32'hFFFFFFFF, q);
    host.acc(1'b0, OFF_IMG1, 32'h0, q);
    chk("img1 off", q, 32'h00000000);
    host.phase(32'h00000ABC, d);
    chk("early hit", 32'(d.hit_regs), 32'h0);
    load(2'b11, 2'b10);
    chk("no strap", 32'(ien), 32'h0);
    $display("test refused done");
  endtask : t_refused

  task automatic t_regs();
    load(2'b11, 2'b10);
    chk("enables", 32'(ien), 32'h3);
    host.acc(1'b1, OFF_FIRST_BAR, 32'h12345FFF, q);
    host.acc(1'b0, OFF_FIRST_BAR, 32'h0, q);
    chk("reg base", q, 32'h12345000);
    host.phase(32'h12345ABC, d);
    chk("reg hit", 32'({d.hit_regs, d.reg_sel}), 32'h1ABC);
    host.phase(32'h12346000, d);
    chk("reg miss", 32'(d.hit_regs), 32'h0);
    lwr(OFF_FIRST_BAR, 32'h00C01000);
    host.acc(1'b0, OFF_FIRST_BAR, 32'h0, q);
    chk("local base", q, 32'h00C01000);
    $display("test regs done");
  endtask : t_regs

  // Shrinking sizes so no stale low bits hide a masking fault
  task automatic t_sizing();
    for (int k = 15; k >= 0; k--)
    begin
      bsc[1] = 4'(k);
      host.acc(1'b1, OFF_IMG1, 32'hFFFFFFFF, q);
      host.acc(1'b0, OFF_IMG1, 32'h0, q);
      chk("img1 size", q, {FULL_MASK << k, 16'h0001});
      host.phase(32'hFFFFFFFF ^ (32'h1 << (15 + k)), d);
      chk("low line", 32'(d.hit_img), 32'h2);
      host.phase(32'hFFFFFFFF ^ (32'h1 << (16 + k)), d);
      chk("high line", 32'(d.hit_img), 32'h0);
    end
    $display("test sizing done");
  endtask : t_sizing

  // Clock enable low: neither bus may move a stored base
  task automatic t_freeze();
    ce = 1'b0;
    lwr(OFF_FIRST_BAR, 32'h77777000);
    host.acc(1'b1, OFF_IMG1, 32'h00000000, q);
    ce = 1'b1;
    host.acc(1'b0, OFF_FIRST_BAR, 32'h0, q);
    chk("frozen reg", q, 32'h00C01000);
    host.acc(1'b0, OFF_IMG1, 32'h0, q);
    chk("frozen img1", q, 32'hFFFF0001);
    $display("test freeze done");
  endtask : t_freeze

  task automatic t_msg();
    lwr(OFF_IMG0, 32'hABCD0008);
    host.acc(1'b1, OFF_IMG0, 32'hABCD0000, q);
    host.acc(1'b0, OFF_IMG0, 32'h0, q);
    chk("img0 reads_side_effect_free_flag", q, 32'hABCD0008);
    chk("pf off", 32'(ipf), 32'h0);
    lpe = 2'b01;
    repeat (2) @(posedge clock);
    #1;
    chk("pf on", 32'(ipf), 32'h1);
    mue = 1'b1;
    host.acc(1'b0, OFF_FIRST_BAR, 32'h0, q);
    chk("window", q, 32'hABCD0008);
    host.acc(1'b0, OFF_IMG0, 32'h0, q);
    chk("moved", q, 32'h00C01000);
    host.phase(32'hABCD0FFC, d);
    chk("rsvd", 32'({d.msg_fwd, d.msg_rsvd}), 32'h1);
    host.phase(32'hABCD1000, d);
    chk("fwd", 32'({d.msg_fwd, d.msg_rsvd}), 32'h2);
    mue = 1'b0;
    host.acc(1'b0, OFF_FIRST_BAR, 32'h0, q);
    chk("home", q, 32'h00C01000);
    $display("test messaging done");
  endtask : t_msg

  task automatic t_dis();
    do_reset(3'b001);
    repeat (2) @(posedge clock);
    #1;
    chk("pci_disable_strap", 32'(ien[0]), 32'h1);
    $display("test disable strap done");
  endtask : t_dis

  initial
  begin
    do_reset(3'b000);
    t_refused();
    do_reset(3'b010);
    t_regs();
    t_sizing();
    t_freeze();
    t_msg();
    t_dis();
    tally_and_finish();
  end
endmodule : pbad_bars_tb
